// ---- dv/cpfm_host_model.sv ----
// host side of the port monitor flags: pull-ups on both open-drain pins and 2-flop sync.
// assumes the flag pins are wired to nothing but this model and the design.
`timescale 1ns/10ps
module cpfm_host_model (
  input  wire logic                     clk,
  input  wire logic                     arst_n,
  input  wire cpfm_pkg::cpfm_flags_type flags,
  output logic                          fault_seen_n,
  output logic                          status_seen_n
);
  // ==========================================================
  // pins and synchronisers
  logic       fault_pin;
  logic       status_pin;
  logic [1:0] fault_sync_r;
  logic [1:0] status_sync_r;
  // released pins float up to the pull-up level
  assign fault_pin  = flags.fault_n_oe ? flags.fault_n_o : 1'b1;
  assign status_pin = flags.status_n_oe ? flags.status_n_o : 1'b1;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fault_sync_r  <= 2'h3;
      status_sync_r <= 2'h3;
    end else begin
      fault_sync_r  <= {fault_sync_r[0], fault_pin};
      status_sync_r <= {status_sync_r[0], status_pin};
    end
  end
  assign fault_seen_n  = fault_sync_r[1];
  assign status_seen_n = status_sync_r[1];
endmodule

// ---- dv/tb_top.sv ----
// directed bench for the port monitor: flags, switch, load status, events and registers.
// assumes shortened counts 4/20/30 and the host model on the flag pins.
`timescale 1ns/10ps
`include "cpfm_regs.svh"
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin bad_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb_top;
  // ==========================================================
  // signals and instances
  logic                     clk = 1'b0;
  logic                     arst_n = 1'b0;
  cpfm_pkg::cpfm_sense_type sense = '0;
  logic                     sw_en = 1'b1;
  logic [3:0]               mode = 4'h5;
  cpfm_pkg::cpfm_flags_type flags;
  logic                     power_switch_on, use_high_limit, use_wake_limit, irq;
  logic [3:0]               reg_addr = 4'h0;
  logic [31:0]              reg_wdata = 32'h0000_0000;
  logic                     reg_wr = 1'b0, reg_rd = 1'b0;
  logic [31:0]              reg_rdata, rd_val;
  logic                     fault_seen_n, status_seen_n;
  int                       bad_count = 0, checks_done = 0;
  always #10 clk = ~clk;
  cpfm_top #(.DEGLITCH_CYC(4), .LOAD_ON_CYC(20), .LOAD_OFF_CYC(30)) u_cpfm_top (
    .clk(clk), .arst_n(arst_n), .sense(sense), .switch_enable_in(sw_en),
    .charge_mode_select_0(mode[3]), .charge_mode_select_1(mode[2]),
    .charge_mode_select_2(mode[1]), .limit_choice_input(mode[0]), .flags(flags),
    .power_switch_on(power_switch_on), .use_high_limit(use_high_limit),
    .use_wake_limit(use_wake_limit), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
  cpfm_host_model u_cpfm_host_model (.clk(clk), .arst_n(arst_n), .flags(flags),
    .fault_seen_n(fault_seen_n), .status_seen_n(status_seen_n));
  // ==========================================================
  // tasks
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // 0 fault seen, 1 status seen, 2 switch on, 3 irq
  function automatic logic sig(int i);
    case (i)
      0: sig = ~fault_seen_n;
      1: sig = ~status_seen_n;
      2: sig = power_switch_on;
      default: sig = irq;
    endcase
  endfunction
  task automatic step(int n);
    repeat (n) @(negedge clk);
  endtask
  // bounded wait; an exhausted bound ends the run
  task automatic wait_sig(int i, logic v, int maxc);
    int k;
    for (k = 0; k < maxc && sig(i) !== v; k++) @(negedge clk);
    `CHK(sig(i), v)
    if (sig(i) !== v) tally_and_finish();
  endtask
  task automatic reg_write(logic [3:0] a, logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask
  task automatic set_mode(logic [3:0] m);
    @(posedge clk);
    mode <= m;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    step(1);
    `CHK(flags, 4'h0)
    reg_read(`CPFM_OFF_ENABLE, rd_val);
    `CHK(rd_val, `CPFM_ENABLE_RST)
    reg_read(4'h1, rd_val);
    `CHK(rd_val, 32'h0000_0000)
    wait_sig(2, 1'b1, 10);
    reg_read(`CPFM_OFF_STATE, rd_val);
    `CHK(rd_val, 32'h0000_0055)
    reg_write(`CPFM_OFF_CLEAR, 32'h0000_000F);
    $display("test reset done");
    // over-temperature: unfiltered fault, switch off, restart after cooling
    @(posedge clk); sense.over_temp_155 <= 1'b1;
    wait_sig(0, 1'b1, 6);
    wait_sig(2, 1'b0, 6);
    step(10);
    `CHK(sig(0), 1'b1)
    @(posedge clk); sense.over_temp_155 <= 1'b0; sense.temp_cooled <= 1'b1;
    wait_sig(2, 1'b1, 8);
    wait_sig(0, 1'b0, 8);
    @(posedge clk); sense.temp_cooled <= 1'b0;
    reg_read(`CPFM_OFF_STATUS, rd_val);
    `CHK(rd_val, 32'h0000_0003)
    $display("test thermal done");
    // current limit: short pulse filtered, long one reported
    @(posedge clk); sense.in_current_limit <= 1'b1;
    @(posedge clk); sense.in_current_limit <= 1'b0;
    step(12);
    `CHK(sig(0), 1'b0)
    @(posedge clk); sense.in_current_limit <= 1'b1;
    wait_sig(0, 1'b1, 14);
    `CHK(sig(2), 1'b1)
    @(posedge clk); sense.over_temp_135 <= 1'b1;
    wait_sig(2, 1'b0, 6);
    @(posedge clk); sense <= cpfm_pkg::cpfm_sense_type'{temp_cooled: 1'b1, default: 1'b0};
    wait_sig(2, 1'b1, 8);
    wait_sig(0, 1'b0, 8);
    @(posedge clk); sense.temp_cooled <= 1'b0;
    $display("test current limit done");
    // undervoltage lockout and its interrupt
    reg_write(`CPFM_OFF_CLEAR, 32'h0000_000F);
    reg_write(`CPFM_OFF_ENABLE, 32'h1 << `CPFM_EV_INPUT_UNDERVOLTAGE_LOCKOUT);
    step(1);
    `CHK(sig(3), 1'b0)
    @(posedge clk); sense.input_undervoltage_lockout <= 1'b1;
    wait_sig(2, 1'b0, 6);
    wait_sig(3, 1'b1, 6);
    step(8);
    `CHK(sig(2), 1'b0)
    @(posedge clk); sense.input_undervoltage_lockout <= 1'b0;
    wait_sig(2, 1'b1, 8);
    reg_read(`CPFM_OFF_STATUS, rd_val);
    `CHK(rd_val[`CPFM_EV_INPUT_UNDERVOLTAGE_LOCKOUT], 1'b1)
    reg_write(`CPFM_OFF_ENABLE, 32'h0000_0000);
    step(2);
    `CHK(sig(3), 1'b0)
    reg_write(`CPFM_OFF_ENABLE, 32'h1 << `CPFM_EV_INPUT_UNDERVOLTAGE_LOCKOUT);
    reg_write(`CPFM_OFF_CLEAR, 32'h0000_000F);
    wait_sig(3, 1'b0, 4);
    // enable pin low and discharge mode both hold the switch off
    @(posedge clk); sw_en <= 1'b0;
    wait_sig(2, 1'b0, 6);
    @(posedge clk); sw_en <= 1'b1;
    wait_sig(2, 1'b1, 6);
    set_mode(4'h1);
    wait_sig(2, 1'b0, 6);
    set_mode(4'h5);
    wait_sig(2, 1'b1, 6);
    $display("test lockout done");
    // port power management in 0111 and 1111, absent in 0110
    for (int j = 0; j < 2; j++) begin
      set_mode(j == 0 ? `CPFM_MODE_DCP_AUTO : `CPFM_MODE_CDP);
      @(posedge clk); sense.above_low_limit_offset <= 1'b1;
      step(12);
      @(posedge clk); sense.above_low_limit_offset <= 1'b0;
      step(2);
      @(posedge clk); sense.above_low_limit_offset <= 1'b1;
      step(14);
      `CHK(sig(1), 1'b0)
      wait_sig(1, 1'b1, 16);
      @(posedge clk); sense.above_low_limit_offset <= 1'b0;
      step(28);
      `CHK(sig(1), 1'b1)
      wait_sig(1, 1'b0, 16);
    end
    @(posedge clk); sense.above_low_limit_offset <= 1'b1;
    wait_sig(1, 1'b1, 30);
    set_mode(4'h6);
    wait_sig(1, 1'b0, 8);
    step(30);
    `CHK(sig(1), 1'b0)
    @(posedge clk); sense.above_low_limit_offset <= 1'b0;
    $display("test power management done");
    // light-load wake mode
    set_mode(`CPFM_MODE_WAKE);
    step(6);
    `CHK({use_high_limit, use_wake_limit}, 2'b10)
    @(posedge clk); sense.below_wake_limit <= 1'b1;
    wait_sig(1, 1'b1, 8);
    `CHK({use_high_limit, use_wake_limit}, 2'b01)
    @(posedge clk); sense.below_wake_limit <= 1'b0;
    wait_sig(1, 1'b0, 8);
    $display("test wake done");
    tally_and_finish();
  end
endmodule

// ---- hdl/cpfm_qual.sv ----
// qualification counter: output rises only after the input held high for a count.
// assumes cond is already synchronous to clk.
`timescale 1ns/10ps
`include "cpfm_regs.svh"
module cpfm_qual #(
  parameter int unsigned COUNT = 10
) (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic cond,
  output logic      qual
);

  localparam int W = $clog2(COUNT + 1);

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic         qual_r;
  wire          hit = (cnt_r == W'(COUNT - 1));

  // any lapse of the condition restarts the interval
  assign cnt_nxt = (!cond || qual_r) ? '0 : (hit ? '0 : cnt_r + W'(1));

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r  <= '0;
      qual_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      // release is immediate so a lapse never leaves a stale qualified level behind
      if (!cond) begin
        qual_r <= 1'b0;
      end else if (hit) begin
        qual_r <= 1'b1;
      end
    end
  end

  assign qual = qual_r;

  a_qual_hold: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(qual_r) |-> $past(cond) && $past(cnt_r) == W'(COUNT - 1))
    else $error("qualified output rose without full interval");

  a_qual_lapse: assert property (@(posedge clk) disable iff (!arst_n)
    !cond |=> !qual_r)
    else $error("qualified output held after condition lapsed");

endmodule

// ---- hdl/cpfm_top.sv ----
// port power switch supervisor: switch enable, fault and load-status flags, events.
// assumes raw comparator flags and mode pins are asynchronous; software on a plain strobe port.
//
// Our own choices: strobed register access and the address map.
`timescale 1ns/10ps
`include "cpfm_regs.svh"

module cpfm_top #(
  parameter int unsigned DEGLITCH_CYC = `CPFM_DEGLITCH_CYC,
  parameter int unsigned LOAD_ON_CYC  = `CPFM_LOAD_ON_CYC,
  parameter int unsigned LOAD_OFF_CYC = `CPFM_LOAD_OFF_CYC
) (
  input  wire logic                   clk,
  input  wire logic                   arst_n,
  input  wire cpfm_pkg::cpfm_sense_type sense,
  input  wire logic                   switch_enable_in,
  input  wire logic                   charge_mode_select_0,
  input  wire logic                   charge_mode_select_1,
  input  wire logic                   charge_mode_select_2,
  input  wire logic                   limit_choice_input,
  output cpfm_pkg::cpfm_flags_type    flags,
  output logic                        power_switch_on,
  output logic                        use_high_limit,
  output logic                        use_wake_limit,
  input  wire logic [3:0]             reg_addr,
  input  wire logic [31:0]            reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic [31:0]                 reg_rdata,
  output logic                        irq
);

  // ==========================================================
  // input synchronisers
  // ==========================================================
  localparam int NIN = 12;

  logic [NIN-1:0] raw_in;
  logic [NIN-1:0] sync1_r;
  logic [NIN-1:0] sync2_r;

  assign raw_in = {sense, switch_enable_in, charge_mode_select_0, charge_mode_select_1,
                   charge_mode_select_2, limit_choice_input};

  // first stage is read only by the second stage
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= raw_in;
      sync2_r <= sync1_r;
    end
  end

  cpfm_pkg::cpfm_sense_type s;
  wire        en_s;
  wire [3:0]  mode;

  assign s    = sync2_r[NIN-1:5];
  assign en_s = sync2_r[4];
  assign mode = sync2_r[3:0];

  // ==========================================================
  // mode decode
  // ==========================================================
  wire mode_wake     = (mode == `CPFM_MODE_WAKE);
  wire mode_ppm      = (mode == `CPFM_MODE_DCP_AUTO) || (mode == `CPFM_MODE_CDP);
  wire mode_discharg = (mode[3:1] == `CPFM_MODE_DISCHARGE);
  wire over_temp     = s.over_temp_155 || (s.over_temp_135 && s.in_current_limit);

  // ==========================================================
  // fault flag path
  // ==========================================================
  logic ilim_deg;

  cpfm_qual #(
    .COUNT (DEGLITCH_CYC)
  ) u_deglitch (
    .clk    (clk),
    .arst_n (arst_n),
    .cond   (s.in_current_limit),
    .qual   (ilim_deg)
  );

  logic thermal_off_r;
  logic fault_r;
  wire  fault_nxt = thermal_off_r || over_temp || ilim_deg;

  // ==========================================================
  // switch control
  // ==========================================================
  cpfm_pkg::cpfm_sw_type sw_r;
  cpfm_pkg::cpfm_sw_type sw_nxt;

  wire sw_allowed = en_s && !s.input_undervoltage_lockout && !mode_discharg;

  always_comb begin
    sw_nxt = sw_r;
    case (sw_r)
      cpfm_pkg::CPFM_SW_OFF: begin
        if (sw_allowed && !over_temp) begin
          sw_nxt = cpfm_pkg::CPFM_SW_ON;
        end
      end
      cpfm_pkg::CPFM_SW_ON: begin
        if (over_temp) begin
          sw_nxt = cpfm_pkg::CPFM_SW_THERMAL;
        end else if (!sw_allowed) begin
          sw_nxt = cpfm_pkg::CPFM_SW_OFF;
        end
      end
      cpfm_pkg::CPFM_SW_THERMAL: begin
        // restart only once the hysteresis comparator reports cooling
        if (s.temp_cooled && !s.over_temp_155) begin
          sw_nxt = cpfm_pkg::CPFM_SW_OFF;
        end
      end
      default: sw_nxt = cpfm_pkg::CPFM_SW_OFF;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sw_r          <= cpfm_pkg::CPFM_SW_OFF;
      thermal_off_r <= 1'b0;
      fault_r       <= 1'b0;
    end else begin
      sw_r          <= sw_nxt;
      thermal_off_r <= (sw_nxt == cpfm_pkg::CPFM_SW_THERMAL);
      fault_r       <= fault_nxt;
    end
  end

  // ==========================================================
  // load status
  // ==========================================================
  logic load_high;

  cpfm_qual #(
    .COUNT (LOAD_ON_CYC)
  ) u_load_on (
    .clk    (clk),
    .arst_n (arst_n),
    .cond   (s.above_low_limit_offset && mode_ppm),
    .qual   (load_high)
  );

  logic load_low_done;

  // release needs 3 s below threshold; mode exit releases at once
  cpfm_qual #(
    .COUNT (LOAD_OFF_CYC)
  ) u_load_off (
    .clk    (clk),
    .arst_n (arst_n),
    .cond   (!s.above_low_limit_offset),
    .qual   (load_low_done)
  );

  logic ppm_active_r;
  logic status_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ppm_active_r <= 1'b0;
    end else if (!mode_ppm) begin
      ppm_active_r <= 1'b0;
    end else if (load_high) begin
      ppm_active_r <= 1'b1;
    end else if (load_low_done) begin
      ppm_active_r <= 1'b0;
    end
  end

  wire status_nxt = mode_wake ? s.below_wake_limit :
                    mode_ppm  ? ppm_active_r : 1'b0;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      status_r <= 1'b0;
    end else begin
      status_r <= status_nxt;
    end
  end

  // in wake mode light load selects wake limit, otherwise high limit
  wire   limit_high_sel  = mode[0] || mode == 4'b0010 || mode == 4'b0110;
  assign use_wake_limit  = mode_wake && s.below_wake_limit;
  assign use_high_limit  = !use_wake_limit && (mode_wake || limit_high_sel);

  assign power_switch_on   = (sw_r == cpfm_pkg::CPFM_SW_ON);
  assign flags.fault_n_o   = 1'b0;
  assign flags.fault_n_oe  = fault_r;
  assign flags.status_n_o  = 1'b0;
  assign flags.status_n_oe = status_r;

  // ==========================================================
  // event registers
  // ==========================================================
  logic [`CPFM_EV_W-1:0] ev_prev_r;
  logic [`CPFM_EV_W-1:0] ev_stat_r;
  logic [`CPFM_EV_W-1:0] ev_en_r;
  logic [31:0]           rdata_r;
  logic [`CPFM_EV_W-1:0] ev_now;
  logic [`CPFM_EV_W-1:0] ev_set;
  logic [`CPFM_EV_W-1:0] ev_clr;

  assign ev_now = {s.input_undervoltage_lockout, status_r, thermal_off_r, fault_r};
  assign ev_set = ev_now & ~ev_prev_r;
  assign ev_clr = (reg_wr && reg_addr == `CPFM_OFF_CLEAR) ? reg_wdata[`CPFM_EV_W-1:0] : '0;

  wire wr_en = reg_wr && reg_addr == `CPFM_OFF_ENABLE;

  // set beats clear in the same cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ev_prev_r <= '0;
      ev_stat_r <= '0;
      ev_en_r   <= '0;
    end else begin
      ev_prev_r <= ev_now;
      ev_stat_r <= (ev_stat_r & ~ev_clr) | ev_set;
      if (wr_en) begin
        ev_en_r <= reg_wdata[`CPFM_EV_W-1:0];
      end
    end
  end

  wire [31:0] state_word = {24'h00_0000, sw_r, power_switch_on, mode};
  wire [31:0] rd_mux = (reg_addr == `CPFM_OFF_STATUS) ? {28'h000_0000, ev_stat_r} :
                       (reg_addr == `CPFM_OFF_ENABLE) ? {28'h000_0000, ev_en_r} :
                       (reg_addr == `CPFM_OFF_STATE)  ? state_word : 32'h0000_0000;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end

  assign reg_rdata = rdata_r;
  assign irq       = |(ev_stat_r & ev_en_r);

  // ==========================================================
  // checks
  // ==========================================================
  a_fault_ot_now: assert property (@(posedge clk) disable iff (!arst_n)
    over_temp |=> flags.fault_n_oe)
    else $error("fault flag late on over-temperature");

  a_fault_clear: assert property (@(posedge clk) disable iff (!arst_n)
    (!fault_nxt) |=> !flags.fault_n_oe)
    else $error("fault flag held after cause cleared");

  a_ilim_glitch: assert property (@(posedge clk) disable iff (!arst_n)
    (!s.in_current_limit && !over_temp && !thermal_off_r) ##1 (!over_temp && !thermal_off_r)
      |=> !flags.fault_n_oe)
    else $error("current limit glitch reached fault flag");

  a_input_undervoltage_lockout_off: assert property (@(posedge clk) disable iff (!arst_n)
    s.input_undervoltage_lockout |=> !power_switch_on)
    else $error("switch on during undervoltage lockout");

  a_hot155_off: assert property (@(posedge clk) disable iff (!arst_n)
    s.over_temp_155 |=> !power_switch_on)
    else $error("switch on above upper thermal threshold");

  a_hot135_lim: assert property (@(posedge clk) disable iff (!arst_n)
    (s.over_temp_135 && s.in_current_limit) |=> !power_switch_on)
    else $error("switch on while hot in current limit");

  a_status_mode: assert property (@(posedge clk) disable iff (!arst_n)
    (!mode_wake && !mode_ppm) |=> !flags.status_n_oe)
    else $error("status flag asserted outside its modes");

  a_wake_status: assert property (@(posedge clk) disable iff (!arst_n)
    (mode_wake && s.below_wake_limit) |=> flags.status_n_oe)
    else $error("light load not signalled in wake mode");

  a_ppm_rise: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(ppm_active_r) |-> $past(load_high) && $past(mode_ppm))
    else $error("load status without qualified overload");

  a_wake_limit: assert property (@(posedge clk) disable iff (!arst_n)
    mode_wake |-> (use_wake_limit != use_high_limit))
    else $error("wake mode limit choice not exclusive");

  a_ppm_release: assert property (@(posedge clk) disable iff (!arst_n)
    $fell(ppm_active_r) |-> $past(load_low_done) || !$past(mode_ppm))
    else $error("load status released before low interval");

  a_ppm_mode: assert property (@(posedge clk) disable iff (!arst_n)
    !mode_ppm |=> !ppm_active_r)
    else $error("power management active outside its modes");

  a_thermal_hold: assert property (@(posedge clk) disable iff (!arst_n)
    (sw_r == cpfm_pkg::CPFM_SW_THERMAL && !s.temp_cooled)
      |=> (sw_r == cpfm_pkg::CPFM_SW_THERMAL))
    else $error("thermal shutdown left before cooling");

  a_cool_restart: assert property (@(posedge clk) disable iff (!arst_n)
    (sw_r == cpfm_pkg::CPFM_SW_THERMAL && s.temp_cooled && !s.over_temp_155)
      |=> (sw_r == cpfm_pkg::CPFM_SW_OFF))
    else $error("no restart after cooling");

  a_thermal_fault: assert property (@(posedge clk) disable iff (!arst_n)
    thermal_off_r |=> flags.fault_n_oe)
    else $error("fault flag released during thermal shutdown");

  a_ilim_fault: assert property (@(posedge clk) disable iff (!arst_n)
    ilim_deg |=> flags.fault_n_oe)
    else $error("qualified current limit not on fault flag");

  a_wake_high: assert property (@(posedge clk) disable iff (!arst_n)
    (mode_wake && !s.below_wake_limit) |-> use_high_limit)
    else $error("wake mode without light load not on high limit");

endmodule

// ---- pkg/cpfm_pkg.sv ----
// types shared by the port monitor modules.
// assumes cpfm_regs.svh sits beside it on the include path.
`include "cpfm_regs.svh"
package cpfm_pkg;

  // comparator flags from the analog front end, all raw and asynchronous
  typedef struct packed {
    logic over_temp_135;
    logic over_temp_155;
    logic temp_cooled;
    logic in_current_limit;
    logic input_undervoltage_lockout;
    logic above_low_limit_offset;
    logic below_wake_limit;
  } cpfm_sense_type;

  typedef struct packed {
    logic status_n_o;
    logic status_n_oe;
    logic fault_n_o;
    logic fault_n_oe;
  } cpfm_flags_type;

  typedef enum logic [2:0] {
    CPFM_SW_OFF     = 3'b001,
    CPFM_SW_ON      = 3'b010,
    CPFM_SW_THERMAL = 3'b100
  } cpfm_sw_type;

endpackage

// ---- pkg/cpfm_regs.svh ----
// timing counts, register offsets, field positions and reset values for the port monitor.
// assumes a 50 MHz system clock; included by the package and the design files.
`ifndef CPFM_REGS_SVH
`define CPFM_REGS_SVH

`define CPFM_CLK_HZ          50000000
`define CPFM_DEGLITCH_US     8
`define CPFM_LOAD_ON_MS      200
`define CPFM_LOAD_OFF_MS     3000
`define CPFM_DEGLITCH_CYC    ((`CPFM_DEGLITCH_US * (`CPFM_CLK_HZ / 1000000)))
`define CPFM_LOAD_ON_CYC     ((`CPFM_LOAD_ON_MS * (`CPFM_CLK_HZ / 1000)))
`define CPFM_LOAD_OFF_CYC    ((`CPFM_LOAD_OFF_MS * (`CPFM_CLK_HZ / 1000)))

`define CPFM_OFF_STATUS      4'h0
`define CPFM_OFF_CLEAR       4'h4
`define CPFM_OFF_ENABLE      4'h8
`define CPFM_OFF_STATE       4'hC
`define CPFM_OFF_CONTROL     4'h0

`define CPFM_EV_FAULT        0
`define CPFM_EV_THERMAL      1
`define CPFM_EV_LOAD         2
`define CPFM_EV_INPUT_UNDERVOLTAGE_LOCKOUT         3
`define CPFM_EV_W            4

`define CPFM_MODE_WAKE       4'b0011
`define CPFM_MODE_DCP_AUTO   4'b0111
`define CPFM_MODE_CDP        4'b1111
`define CPFM_MODE_DISCHARGE  3'b000

`define CPFM_ENABLE_RST      32'h0000_0000

`endif
